/* File: design/pscp_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module pscp_dev #(
   parameter logic [15:0] USR_EDGES = pscp_pkg::USR_EDGES
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   pscp_if.dev link,
   input wire logic chain_select_n_i,
   input wire logic user_init_clock_i,
   input wire logic user_clock_option_i,
   input wire logic cable_mode_i,
   input wire logic frame_error_i,
   output logic chain_select_n_o,
   output logic [7:0] cfg_byte_o,
   output logic cfg_byte_valid_o,
   output logic user_mode_o,
   output logic halted_o
);
   pscp_pkg::pscp_dev_state_t state;
   pscp_pkg::pscp_dev_state_t next_state;
   logic [15:0] cnt;
   logic [15:0] usr_cnt;
   logic req_s1, req_s2, st_s1, st_s2, cd_s1, cd_s2;
   logic usr_s1, usr_s2, usr_s3;
   logic rxd_s1, rxd_s2, go_s1, go_s2;
   logic bt_s1, bt_s2, bt_s3;
   logic rx_hold;
   logic own_s1, own_s2;
   // Link-domain state.
   logic [7:0] shift;
   logic [7:0] rx_byte;
   logic [2:0] bit_idx;
   logic [15:0] bit_total;
   logic rx_complete;
   logic byte_tgl;
   logic [1:0] fall_cnt;

   wire req_low = !req_s2;
   // Our own release takes two cycles to show in the synchronised line, so
   // the own enable is delayed alike before blaming another chain member.
   wire others_err = !st_s2 && !own_s2 && !link.status_oe;
   wire usr_opt = user_clock_option_i && !cable_mode_i;
   wire usr_edge = usr_s2 && !usr_s3;
   wire init_go = go_s2 && cd_s2;
   wire por_done = cnt == pscp_pkg::POR_CYC - 16'h0001;
   wire pulse_done = cnt >= pscp_pkg::STATUS_MIN_CYC;
   wire osc_done = cnt >= pscp_pkg::CD2UM_MIN_CYC - 16'h0001;
   wire usr_en = cnt >= pscp_pkg::CD2CU_CYC - 16'h0001;
   wire usr_done = usr_cnt >= USR_EDGES;
   wire init_done = usr_opt ? usr_done : osc_done;
   wire byte_evt = bt_s2 != bt_s3;
   wire take_bit = !chain_select_n_i && !rx_complete;
   wire [7:0] next_shift = {link.config_serial_data, shift[7:1]};

   always_comb
   begin
      next_state = state;
      unique case (state)
         pscp_pkg::DS_POR:
            if (por_done)
               next_state = req_low ? pscp_pkg::DS_RESET : pscp_pkg::DS_CONFIG;
         pscp_pkg::DS_RESET:
            if (!req_low && pulse_done)
               next_state = pscp_pkg::DS_CONFIG;
         pscp_pkg::DS_CONFIG:
            if (frame_error_i)
               next_state = pscp_pkg::DS_ERROR;
            else if (others_err)
               next_state = pscp_pkg::DS_HALT;
            else if (rxd_s2 && cd_s2)
               next_state = pscp_pkg::DS_INIT;
         pscp_pkg::DS_INIT:
            if (others_err)
               next_state = pscp_pkg::DS_HALT;
            else if (init_go && init_done)
               next_state = pscp_pkg::DS_USER;
         pscp_pkg::DS_USER:
            next_state = state;
         pscp_pkg::DS_ERROR:
            if (pulse_done)
               next_state = pscp_pkg::DS_HALT;
         pscp_pkg::DS_HALT:
            next_state = state;
         default:
            next_state = pscp_pkg::DS_POR;
      endcase
      // A low request forces DS_RESET from any state after power-on.
      if (req_low && state != pscp_pkg::DS_POR)
         next_state = pscp_pkg::DS_RESET;
   end

   always_ff @(posedge clk_i)
   begin
      req_s1 <= link.config_request_n;
      req_s2 <= req_s1;
      st_s1 <= link.status_n;
      st_s2 <= st_s1;
      own_s1 <= link.status_oe;
      own_s2 <= own_s1;
      cd_s1 <= link.config_complete;
      cd_s2 <= cd_s1;
      usr_s1 <= user_init_clock_i;
      usr_s2 <= usr_s1;
      usr_s3 <= usr_s2;
      rxd_s1 <= rx_complete;
      rxd_s2 <= rxd_s1;
      go_s1 <= (fall_cnt == pscp_pkg::FALLS);
      go_s2 <= go_s1;
      bt_s1 <= byte_tgl;
      bt_s2 <= bt_s1;
      bt_s3 <= bt_s2;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state <= pscp_pkg::DS_POR;
         cnt <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         if (next_state != state)
            cnt <= 16'h0000;
         else if (cnt != 16'hffff)
            cnt <= cnt + 16'h0001;
      end
   end

   // User-clock edges count only once the user clock is allowed to run.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || state != pscp_pkg::DS_INIT || !init_go)
         usr_cnt <= 16'h0000;
      else if (usr_en && usr_edge && !usr_done)
         usr_cnt <= usr_cnt + 16'h0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_hold <= 1'b1;
         link.status_oe <= 1'b1;
         link.complete_oe <= 1'b1;
         user_mode_o <= 1'b0;
         halted_o <= 1'b0;
         cfg_byte_o <= 8'h00;
         cfg_byte_valid_o <= 1'b0;
      end
      else
      begin
         rx_hold <= next_state == pscp_pkg::DS_POR ||
                    next_state == pscp_pkg::DS_RESET ||
                    next_state == pscp_pkg::DS_ERROR ||
                    next_state == pscp_pkg::DS_HALT;
         // Status low at power-on, reset pulse and own error.
         link.status_oe <= next_state == pscp_pkg::DS_POR ||
                           next_state == pscp_pkg::DS_RESET ||
                           next_state == pscp_pkg::DS_ERROR;
         link.complete_oe <= !(next_state == pscp_pkg::DS_INIT ||
                               next_state == pscp_pkg::DS_USER ||
                               (next_state == pscp_pkg::DS_CONFIG &&
                                rxd_s2));
         user_mode_o <= next_state == pscp_pkg::DS_USER;
         halted_o <= next_state == pscp_pkg::DS_HALT;
         cfg_byte_valid_o <= byte_evt && state == pscp_pkg::DS_CONFIG;
         if (byte_evt && state == pscp_pkg::DS_CONFIG)
            cfg_byte_o <= rx_byte;
      end
   end

   assign link.status_out = 1'b0;
   assign link.complete_out = 1'b0;

   // The link clock stands still between frames, so the receiver is
   // cleared asynchronously; release is quiet because the host waits
   // long before its first edge.
   always_ff @(posedge link.config_serial_clock or posedge rx_hold)
   begin
      if (rx_hold)
      begin
         shift <= 8'h00;
         rx_byte <= 8'h00;
         bit_idx <= 3'h0;
         bit_total <= 16'h0000;
         rx_complete <= 1'b0;
         byte_tgl <= 1'b0;
         chain_select_n_o <= 1'b1;
      end
      else if (take_bit)
      begin
         shift <= next_shift;
         bit_idx <= bit_idx + 3'h1;
         bit_total <= bit_total + 16'h0001;
         if (bit_idx == 3'h7)
         begin
            rx_byte <= next_shift;
            byte_tgl <= !byte_tgl;
         end
         if (bit_total == pscp_pkg::LAST_BIT)
         begin
            rx_complete <= 1'b1;
            chain_select_n_o <= 1'b0;
         end
      end
   end

   always_ff @(negedge link.config_serial_clock or posedge rx_hold)
   begin
      if (rx_hold)
         fall_cnt <= 2'h0;
      else if (rx_complete && fall_cnt != pscp_pkg::FALLS)
         fall_cnt <= fall_cnt + 2'h1;
   end
endmodule
`default_nettype wire

/* File: design/pscp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pscp_host #(
   parameter logic [15:0] CF2CK_CYC = pscp_pkg::CF2CK_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   pscp_if.host link,
   input wire logic start_i,
   input wire logic [7:0] byte_i,
   input wire logic byte_valid_i,
   output logic byte_ready_o,
   output logic busy_o,
   output logic done_o,
   output logic error_o
);
   pscp_pkg::pscp_host_state_t state;
   pscp_pkg::pscp_host_state_t next_state;
   logic [15:0] cnt;
   logic [15:0] st_cnt;
   logic [7:0] sh;
   logic [2:0] bit_idx;
   logic tail;
   logic st_s1, st_s2, cd_s1, cd_s2;

   wire sending = state == pscp_pkg::HS_LOAD ||
                  state == pscp_pkg::HS_LOW || state == pscp_pkg::HS_HIGH;
   wire st_err = sending && !st_s2;
   wire req_done = cnt >= pscp_pkg::CFG_CYC;
   wire wait_done = cnt >= CF2CK_CYC - 16'h0001 &&
                    st_cnt >= pscp_pkg::ST2CK_CYC - 16'h0001;

   assign byte_ready_o = state == pscp_pkg::HS_LOAD && !cd_s2 && st_s2;

   // The serial clock is one cycle low, one high per bit (20 MHz), plus an HS_LOAD low cycle before each byte.
   always_comb
   begin
      next_state = state;
      unique case (state)
         pscp_pkg::HS_IDLE:
            if (start_i)
               next_state = pscp_pkg::HS_REQ;
         pscp_pkg::HS_REQ:
            if (req_done)
               next_state = pscp_pkg::HS_WAIT;
         pscp_pkg::HS_WAIT:
            if (wait_done)
               next_state = pscp_pkg::HS_LOAD;
         pscp_pkg::HS_LOAD:
            if (cd_s2)
               next_state = pscp_pkg::HS_TAIL_HIGH;
            else if (byte_valid_i)
               next_state = pscp_pkg::HS_LOW;
         pscp_pkg::HS_LOW:
            next_state = pscp_pkg::HS_HIGH;
         pscp_pkg::HS_HIGH:
            next_state = bit_idx == 3'h7 ? pscp_pkg::HS_LOAD
                                         : pscp_pkg::HS_LOW;
         pscp_pkg::HS_TAIL_HIGH:
            next_state = pscp_pkg::HS_TAIL_LOW;
         pscp_pkg::HS_TAIL_LOW:
            next_state = tail ? pscp_pkg::HS_IDLE
                              : pscp_pkg::HS_TAIL_HIGH;
      endcase
      if (st_err)
         next_state = pscp_pkg::HS_REQ;
   end

   always_ff @(posedge clk_i)
   begin
      st_s1 <= link.status_n;
      st_s2 <= st_s1;
      cd_s1 <= link.config_complete;
      cd_s2 <= cd_s1;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state <= pscp_pkg::HS_IDLE;
         cnt <= 16'h0000;
         st_cnt <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         if (next_state != state)
            cnt <= 16'h0000;
         else if (cnt != 16'hffff)
            cnt <= cnt + 16'h0001;
         if (!st_s2)
            st_cnt <= 16'h0000;
         else if (st_cnt != 16'hffff)
            st_cnt <= st_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         sh <= 8'h00;
         bit_idx <= 3'h0;
         tail <= 1'b0;
         link.config_request_n <= 1'b1;
         link.config_serial_clock <= 1'b0;
         link.config_serial_data <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         error_o <= 1'b0;
      end
      else
      begin
         if (state == pscp_pkg::HS_LOAD && next_state == pscp_pkg::HS_LOW)
         begin
            sh <= byte_i;
            bit_idx <= 3'h0;
         end
         else if (state == pscp_pkg::HS_HIGH)
         begin
            sh <= {1'b0, sh[7:1]};
            bit_idx <= bit_idx + 3'h1;
         end
         if (state == pscp_pkg::HS_LOAD)
            tail <= 1'b0;
         else if (state == pscp_pkg::HS_TAIL_LOW)
            tail <= 1'b1;
         link.config_request_n <= next_state != pscp_pkg::HS_REQ;
         // Clock rests low outside frames, never floating.
         link.config_serial_clock <= next_state == pscp_pkg::HS_HIGH ||
                                     next_state == pscp_pkg::HS_TAIL_HIGH;
         if (next_state == pscp_pkg::HS_LOW)
            link.config_serial_data <= (state == pscp_pkg::HS_LOAD) ?
                                       byte_i[0] : sh[1];
         busy_o <= next_state != pscp_pkg::HS_IDLE;
         if (start_i)
            done_o <= 1'b0;
         else if (state == pscp_pkg::HS_TAIL_LOW && tail)
            done_o <= 1'b1;
         error_o <= st_err;
      end
   end
endmodule
`default_nettype wire

/* File: design/pscp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pscp_if;
   logic config_request_n;
   logic config_serial_clock;
   logic config_serial_data;
   logic status_out;
   logic status_oe;
   logic status_ext_oe;
   logic complete_out;
   logic complete_oe;
   logic complete_ext_oe;
   // Open-drain lines with pull-ups; other chain members use the ext enables.
   wire status_n = ~(status_oe | status_ext_oe);
   wire config_complete = ~(complete_oe | complete_ext_oe);
   modport dev (
      input config_request_n, config_serial_clock, config_serial_data,
      input status_n, config_complete,
      output status_out, status_oe, complete_out, complete_oe
   );
   modport host (
      output config_request_n, config_serial_clock, config_serial_data,
      input status_n, config_complete
   );
endinterface
`default_nettype wire

/* File: design/pscp_pkg.sv */
package pscp_pkg;
   localparam int CLK_MHZ = 40;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 16;
   // Bitstream length in bits; plain default for this block.
   localparam int CFG_BITS = 64;
   localparam int POR_US = 100;
   localparam int CF2CD_MAX_NS = 800;
   localparam int CF2ST0_MAX_NS = 800;
   localparam int CFG_MIN_US = 2;
   localparam int STATUS_MIN_US = 10;
   localparam int STATUS_MAX_US = 500;
   localparam int CF2ST1_MAX_US = 500;
   localparam int CF2CK_MIN_US = 500;
   localparam int ST2CK_MIN_US = 2;
   localparam int CD2UM_MIN_US = 55;
   localparam int CD2UM_MAX_US = 150;
   localparam int CD2CU_PERIODS = 4;
   localparam int SCLK_MAX_PERIOD_NS = 8;
   localparam int USR_PERIODS = 8532;
   localparam int INIT_FALL_EDGES = 2;
   localparam logic [CNT_W-1:0] POR_CYC = CNT_W'(POR_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] CFG_CYC = CNT_W'(CFG_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] STATUS_MIN_CYC =
      CNT_W'(STATUS_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] CF2CK_CYC = CNT_W'(CF2CK_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] ST2CK_CYC = CNT_W'(ST2CK_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] CD2UM_MIN_CYC =
      CNT_W'(CD2UM_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] CD2CU_CYC = CNT_W'(
      (CD2CU_PERIODS * SCLK_MAX_PERIOD_NS * CLK_MHZ + 999) / 1000 + 1);
   localparam logic [CNT_W-1:0] USR_EDGES = CNT_W'(USR_PERIODS);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(CFG_BITS - 1);
   localparam logic [1:0] FALLS = 2'(INIT_FALL_EDGES);
   typedef enum logic [2:0] {
      DS_POR, DS_RESET, DS_CONFIG, DS_INIT, DS_USER, DS_ERROR, DS_HALT
   } pscp_dev_state_t;
   typedef enum logic [2:0] {
      HS_IDLE, HS_REQ, HS_WAIT, HS_LOAD, HS_LOW, HS_HIGH,
      HS_TAIL_LOW, HS_TAIL_HIGH
   } pscp_host_state_t;
endpackage

/* File: tb/passive_serial_config_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module passive_serial_config_port_tb;
   localparam logic [15:0] USR_E = 16'h0014;
   localparam logic [15:0] CK_CYC = 16'h00c8;
   typedef struct packed {
      logic opt;
      logic cable;
      logic [7:0] pat;
      logic [15:0] lo;
      logic [15:0] hi;
   } pscp_row_t;
   // Init clock option, cable flag, data base, window from done to user.
   localparam pscp_row_t ROWS [4] = '{
      '{1'b0, 1'b0, 8'h02, 16'h0898, 16'h1770},
      '{1'b1, 1'b0, 8'h1b, 16'h001e, 16'h012c},
      '{1'b1, 1'b1, 8'hee, 16'h0898, 16'h1770},
      '{1'b0, 1'b1, 8'hfa, 16'h0898, 16'h1770}
   };
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic user_init_clock_i = 1'b0;
   logic start_i = 1'b0;
   logic user_clock_option_i = 1'b0;
   logic cable_mode_i = 1'b0;
   logic frame_error_i = 1'b0;
   logic [7:0] pat = 8'h00;
   logic [3:0] fidx = 4'h0;
   logic [7:0] sh, byte_i, cfg_byte_o;
   logic byte_valid_i, byte_ready_o, busy_o, done_o, error_o;
   logic cfg_byte_valid_o, user_mode_o, halted_o, err_seen, hs;
   int mismatches = 0;
   int comparisons = 0;
   int bidx = 0;
   int wbits = 0;
   pscp_if link_if ();
   always #12.5 clk_i = ~clk_i;
   always #24 user_init_clock_i = ~user_init_clock_i;
   function automatic logic [7:0] eb(logic [7:0] s, int i);
      return 8'(s + 8'h3b * i);
   endfunction
   assign byte_valid_i = ~fidx[3];
   assign byte_i = eb(pat, int'(fidx[2:0]));
   pscp_dev #(.USR_EDGES(USR_E)) i_pscp_dev (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link_if.dev),
      .chain_select_n_i(1'b0), .user_init_clock_i(user_init_clock_i),
      .user_clock_option_i(user_clock_option_i),
      .cable_mode_i(cable_mode_i), .frame_error_i(frame_error_i),
      .chain_select_n_o(), .cfg_byte_o(cfg_byte_o),
      .cfg_byte_valid_o(cfg_byte_valid_o), .user_mode_o(user_mode_o),
      .halted_o(halted_o));
   pscp_host #(.CF2CK_CYC(CK_CYC)) i_pscp_host (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link_if.host),
      .start_i(start_i), .byte_i(byte_i), .byte_valid_i(byte_valid_i),
      .byte_ready_o(byte_ready_o), .busy_o(busy_o), .done_o(done_o),
      .error_o(error_o));
   pscp_assertions #(.CF2CK_CYC(CK_CYC)) i_pscp_assertions (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .config_request_n(link_if.config_request_n),
      .config_serial_clock(link_if.config_serial_clock),
      .status_n(link_if.status_n),
      .config_complete(link_if.config_complete),
      .status_oe(link_if.status_oe), .complete_oe(link_if.complete_oe));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic timeout(input logic hit);
      if (hit)
      begin
         check(1'b1, 1'b0);
         stop_test();
      end
   endtask
   function automatic logic [4:0] rv();
      return {link_if.status_oe, link_if.complete_oe, user_mode_o,
         cfg_byte_valid_o, busy_o};
   endfunction
   always @(posedge clk_i)
   begin
      if (error_o === 1'b1)
      begin
         err_seen = 1'b1;
         bidx = 0;
         wbits = 0;
      end
      else if (cfg_byte_valid_o === 1'b1)
      begin
         check(cfg_byte_o, eb(pat, bidx));
         bidx++;
      end
   end
   always @(posedge clk_i)
      if (start_i || error_o)
         fidx <= 4'h0;
      else if (byte_valid_i && byte_ready_o)
         fidx <= fidx + 4'h1;
   // The wire itself is decoded, so bit order is judged apart from the
   // device's own assembly of bytes.
   always @(posedge link_if.config_serial_clock)
      if (wbits < 64)
      begin
         sh = {link_if.config_serial_data, sh[7:1]};
         wbits++;
         if (wbits % 8 == 0)
            check(sh, eb(pat, wbits / 8 - 1));
      end
   task automatic kick();
      @(posedge clk_i);
      start_i <= 1'b1;
      bidx = 0;
      wbits = 0;
      @(posedge clk_i);
      start_i <= 1'b0;
   endtask
   task automatic run(input int r);
      int t;
      int td;
      td = -1;
      @(posedge clk_i);
      user_clock_option_i <= ROWS[r].opt;
      cable_mode_i <= ROWS[r].cable;
      pat <= ROWS[r].pat;
      kick();
      for (t = 0; t < 40000; t++)
      begin
         @(posedge clk_i);
         if (link_if.config_complete !== 1'b1)
            td = -1;
         else if (td < 0)
            td = t;
         if (t > 100 && td >= 0 && user_mode_o === 1'b1)
            break;
      end
      timeout(t >= 40000);
      check((t - td) >= ROWS[r].lo && (t - td) <= ROWS[r].hi, 1'b1);
      for (t = 0; t < 400 && done_o !== 1'b1; t++)
         @(posedge clk_i);
      timeout(t >= 400);
      repeat (20) @(posedge clk_i);
      #1;
      check(bidx, 8);
      check({link_if.config_serial_clock, link_if.config_request_n, link_if.status_n, link_if.config_complete}, 4'h7);
      $display("run %0d finished", r);
   endtask
   task automatic inject(input logic ext);
      int t;
      kick();
      for (t = 0; t < 20000 && wbits < 16; t++)
         @(posedge clk_i);
      timeout(t >= 20000);
      err_seen = 1'b0;
      hs = 1'b0;
      if (ext)
         link_if.status_ext_oe <= 1'b1;
      else
         frame_error_i <= 1'b1;
      repeat (600)
      begin
         @(posedge clk_i);
         frame_error_i <= 1'b0;
         // An own error pulls status low and the host restarts at once,
         // so only another member's error leaves the device halted.
         hs = hs | ((ext ? halted_o : link_if.status_oe) === 1'b1);
      end
      link_if.status_ext_oe <= 1'b0;
      check(hs, 1'b1);
      check(err_seen, 1'b1);
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      check(rv(), 5'h18);
      $display("inject %0d finished", ext);
   endtask
   initial
   begin
      link_if.status_ext_oe = 1'b0;
      link_if.complete_ext_oe = 1'b0;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      check(rv(), 5'h18);
      repeat (100) @(posedge clk_i);
      #1;
      check({link_if.status_n, link_if.config_complete}, 2'h0);
      $display("power-up finished");
      for (int r = 0; r < 4; r++)
         run(r);
      inject(1'b1);
      inject(1'b0);
      run(0);
      stop_test();
   end
endmodule
`default_nettype wire

/* File: tb/pscp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pscp_assertions #(
   parameter logic [15:0] CF2CK_CYC = pscp_pkg::CF2CK_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic config_request_n,
   input wire logic config_serial_clock,
   input wire logic status_n,
   input wire logic config_complete,
   input wire logic status_oe,
   input wire logic complete_oe
);
   // Run lengths saturate, since the spans exceed what a delay can reach.
   logic [15:0] st_low, rel_cnt, req_low, req_high, st_high;
   function automatic logic [15:0] sat(logic [15:0] v, logic en);
      return en ? ((&v) ? v : v + 16'h0001) : 16'h0000;
   endfunction
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         {st_low, rel_cnt, req_low, req_high, st_high} <= 80'h0;
      else
      begin
         st_low <= sat(st_low, status_oe);
         rel_cnt <= sat(rel_cnt, config_request_n & status_oe);
         req_low <= sat(req_low, ~config_request_n);
         req_high <= sat(req_high, config_request_n);
         st_high <= sat(st_high, status_n);
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   chk_req_done_low: assert property ($fell(config_request_n) |-> ##[0:32] complete_oe)
      else $error("done line not pulled low after request");
   chk_req_status_low: assert property ($fell(config_request_n) |-> ##[0:32] status_oe)
      else $error("status line not pulled low after request");
   chk_done_held_low: assert property (!config_request_n [*6] |-> !config_complete)
      else $error("done line high during reconfiguration");
   chk_status_pulse: assert property ($fell(status_oe) |-> st_low >= 16'h0190 && st_low <= 16'h4e20)
      else $error("own status pulse width out of range");
   chk_status_release: assert property (config_request_n && status_oe |-> rel_cnt <= 16'h4e20)
      else $error("status held low too long after request high");
   chk_request_width: assert property ($rose(config_request_n) |-> req_low >= 16'h0050)
      else $error("request pulse too short");
   chk_clock_after_request: assert property ($rose(config_serial_clock) |-> req_high >= CF2CK_CYC)
      else $error("serial clock too soon after request high");
   chk_clock_after_status: assert property ($rose(config_serial_clock) && status_n |-> st_high >= 16'h0050)
      else $error("serial clock too soon after status high");
   chk_init_falls: assert property ($rose(config_complete) |-> ##[1:40] $fell(config_serial_clock) ##[1:8] $fell(config_serial_clock))
      else $error("two falling clocks missing after done");
endmodule
`default_nettype wire
